// *** core/dfr_defs.svh ***
/*
 Named numbers of the drive fault response controller: register byte
 offsets, field positions, reset values, codes and timing figures.
 Assumes inclusion by its bare name from the modules.
*/
`ifndef DFR_DEFS_SVH
`define DFR_DEFS_SVH

// Register byte offsets on the AXI4-Lite slave
`define DFR_ADDR_W          8
`define DFR_REG_CTRL        8'h00
`define DFR_REG_FUNC_SEL0   8'h04
`define DFR_REG_FUNC_SEL1   8'h08
`define DFR_REG_STATUS      8'h0C
`define DFR_REG_IRQ_STAT    8'h10
`define DFR_REG_IRQ_MASK    8'h14
`define DFR_REG_CODE        8'h18

// Control register fields
`define DFR_CTRL_RESET_BIT  0
`define DFR_CTRL_FSTOP_LO   1
`define DFR_CTRL_FSTOP_HI   2
`define DFR_CTRL_ASTOP_LO   3
`define DFR_CTRL_ASTOP_HI   4

// Status and interrupt bit positions
`define DFR_EV_FAULT        0
`define DFR_EV_ALARM        1
`define DFR_EV_OPER         2
`define DFR_EV_TUNE         3
`define DFR_EV_COPY         4
`define DFR_EV_N            5
`define DFR_ST_RUN_PERMIT   5
`define DFR_ST_MOTOR_EN     6

// Reset values
`define DFR_FUNC_SEL_RST    8'h00
`define DFR_IRQ_MASK_RST    5'h00
`define DFR_CODE_NONE       8'h00

// Function select code that routes the minor-fault state to an output
`define DFR_FUNC_MINOR      8'h0A
`define DFR_N_PROG_OUT      2

// AXI responses
`define DFR_RESP_OKAY       2'h0
`define DFR_RESP_SLVERR     2'h2

// Lamp flash timing
`define DFR_CLK_KHZ         125_000
`define DFR_BLINK_HALF_MS   500

`endif

// *** core/dfr_pkg.sv ***
/*
 Types shared by the drive fault response controller modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dfr_pkg;

	// Class of the condition shown on the operator display
	typedef enum logic [2:0]
	{
		DFR_SHOW_NONE,
		DFR_SHOW_FAULT,
		DFR_SHOW_TUNE,
		DFR_SHOW_OPER,
		DFR_SHOW_COPY,
		DFR_SHOW_ALARM
	} dfr_show_type;

	// Stopping method; encoding matches the control register field
	typedef enum logic [1:0]
	{
		DFR_STOP_COAST,
		DFR_STOP_RAMP,
		DFR_STOP_FAST,
		DFR_STOP_RSVD
	} dfr_stop_type;

endpackage

// *** core/dfr_blinker.sv ***
/*
 Square-wave generator for the flashing trouble lamp.
 Assumes one clock; the half period is given in cycles.
*/
module dfr_blinker
#(
	parameter int unsigned HALF_CYCLES = 62_500_000
)
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic rstn,
	// Control and output
	input  wire logic run,
	output logic      blink
);

	logic [31:0] count_r;
	logic        blink_r;
	wire         wrap = (count_r == 32'(HALF_CYCLES - 1));

	// Restart with lamp lit, so a new alarm shows at once
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			count_r <= 32'h0000_0000;
			blink_r <= 1'b1;
		end
		else if (!run)
		begin
			count_r <= 32'h0000_0000;
			blink_r <= 1'b1;
		end
		else if (wrap)
		begin
			count_r <= 32'h0000_0000;
			blink_r <= ~blink_r;
		end
		else
			count_r <= count_r + 32'h0000_0001;
	end

	assign blink = blink_r;

endmodule

// *** core/dfr_top.sv ***
/*
 Drive fault response controller: classifies detected conditions,
 drives display, lamp, relay, programmable outputs and motor permit.
 Assumes detection inputs are synchronous to clock; the panel key pin
 is asynchronous. Software reaches registers over AXI4-Lite.
*/
`include "dfr_defs.svh"
module dfr_top
#(
	parameter int unsigned BLINK_HALF_CYCLES =
		`DFR_BLINK_HALF_MS * `DFR_CLK_KHZ
)
(
	// Clock and reset
	input  wire logic                      clock,
	input  wire logic                      rstn,
	// AXI4-Lite write channels
	input  wire logic [`DFR_ADDR_W-1:0]    awaddr,
	input  wire logic                      awvalid,
	output logic                           awready,
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output logic                           wready,
	output logic [1:0]                     bresp,
	output logic                           bvalid,
	input  wire logic                      bready,
	// AXI4-Lite read channels
	input  wire logic [`DFR_ADDR_W-1:0]    araddr,
	input  wire logic                      arvalid,
	output logic                           arready,
	output logic [31:0]                    rdata,
	output logic [1:0]                     rresp,
	output logic                           rvalid,
	input  wire logic                      rready,
	// Detection logic
	input  wire logic                      fault_event,
	input  wire logic [7:0]                fault_code,
	input  wire logic                      fault_stop_selectable,
	input  wire logic                      alarm_present,
	input  wire logic [7:0]                alarm_code,
	input  wire logic                      alarm_stop_request,
	input  wire logic                      setting_conflict,
	input  wire logic [7:0]                conflict_code,
	input  wire logic                      tuning_start,
	input  wire logic                      tuning_error,
	input  wire logic                      copy_error,
	input  wire logic [7:0]                error_code,
	// Operator panel
	input  wire logic                      panel_key_pin,
	output logic [7:0]                     display_code,
	output dfr_pkg::dfr_show_type          display_class,
	output logic                           display_flash,
	output logic                           trouble_lamp,
	// Contact outputs
	output logic                           fault_relay_make_path,
	output logic                           fault_relay_break_path,
	output logic [`DFR_N_PROG_OUT-1:0]     programmable_output,
	// Motor control
	output logic                           run_permit,
	output logic                           motor_output_enable,
	output dfr_pkg::dfr_stop_type          stop_method,
	// Interrupt
	output logic                           irq
);
	import dfr_pkg::*;

	// Latched conditions
	logic               fault_r;
	logic [7:0]         fault_code_r;
	logic               fault_sel_r;
	logic               tune_r;
	logic [7:0]         tune_code_r;
	logic               copy_r;
	logic [7:0]         copy_code_r;

	// Configuration
	logic [1:0]         fstop_cfg_r;
	logic [1:0]         astop_cfg_r;
	logic [7:0]         func_sel_r [`DFR_N_PROG_OUT];
	logic [`DFR_EV_N-1:0] irq_stat_r;
	logic [`DFR_EV_N-1:0] irq_mask_r;

	// Registered outputs
	logic [7:0]         disp_code_r;
	dfr_show_type       disp_class_r;
	logic               make_r;
	logic               permit_r;
	logic               motor_en_r;
	dfr_stop_type       stop_r;
	logic [`DFR_N_PROG_OUT-1:0] prog_r;

	// Bus slave state
	logic               aw_have_r;
	logic               w_have_r;
	logic [`DFR_ADDR_W-1:0] aw_addr_r;
	logic [31:0]        w_data_r;
	logic               w_lane0_r;
	logic               bvalid_r;
	logic [1:0]         bresp_r;
	logic               rvalid_r;
	logic [31:0]        rdata_r;
	logic [1:0]         rresp_r;

	// Panel key synchroniser and edge; alarm and operation error edge flops
	logic               key_meta_r;
	logic               key_sync_r;
	logic               key_prev_r;
	logic               alarm_prev_r;
	logic               oper_prev_r;

	// Key pin passes two flops before use
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			key_meta_r <= 1'b0;
			key_sync_r <= 1'b0;
			key_prev_r <= 1'b0;
		end
		else
		begin
			key_meta_r <= panel_key_pin;
			key_sync_r <= key_meta_r;
			key_prev_r <= key_sync_r;
		end
	end

	wire key_press = key_sync_r & ~key_prev_r;

	// Write decode: fires once both address and data are held
	wire aw_take  = awvalid & awready;
	wire w_take   = wvalid & wready;
	wire do_write = aw_have_r & w_have_r & ~bvalid_r;
	wire wr_ctrl  = do_write & w_lane0_r & (aw_addr_r == `DFR_REG_CTRL);
	wire wr_fs0   = do_write & w_lane0_r &
		(aw_addr_r == `DFR_REG_FUNC_SEL0);
	wire wr_fs1   = do_write & w_lane0_r &
		(aw_addr_r == `DFR_REG_FUNC_SEL1);
	wire wr_istat = do_write & w_lane0_r &
		(aw_addr_r == `DFR_REG_IRQ_STAT);
	wire wr_imask = do_write & w_lane0_r &
		(aw_addr_r == `DFR_REG_IRQ_MASK);
	wire wr_hit   = (aw_addr_r == `DFR_REG_CTRL) |
		(aw_addr_r == `DFR_REG_FUNC_SEL0) |
		(aw_addr_r == `DFR_REG_FUNC_SEL1) |
		(aw_addr_r == `DFR_REG_STATUS) |
		(aw_addr_r == `DFR_REG_IRQ_STAT) |
		(aw_addr_r == `DFR_REG_IRQ_MASK) |
		(aw_addr_r == `DFR_REG_CODE);
	wire fault_reset = wr_ctrl & w_data_r[`DFR_CTRL_RESET_BIT];

	assign awready = ~aw_have_r;
	assign wready  = ~w_have_r;

	// Write channel holding and response
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h0000_0000;
			w_lane0_r <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `DFR_RESP_OKAY;
		end
		else
		begin
			if (aw_take)
			begin
				aw_have_r <= 1'b1;
				aw_addr_r <= awaddr;
			end
			if (w_take)
			begin
				w_have_r  <= 1'b1;
				w_data_r  <= wdata;
				w_lane0_r <= wstrb[0];
			end
			if (do_write)
			begin
				aw_have_r <= 1'b0;
				w_have_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_hit ? `DFR_RESP_OKAY : `DFR_RESP_SLVERR;
			end
			else if (bvalid_r & bready)
				bvalid_r <= 1'b0;
		end
	end

	// Configuration registers; all fields sit in byte lane 0
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			fstop_cfg_r   <= 2'h0;
			astop_cfg_r   <= 2'h0;
			func_sel_r[0] <= `DFR_FUNC_SEL_RST;
			func_sel_r[1] <= `DFR_FUNC_SEL_RST;
			irq_mask_r    <= `DFR_IRQ_MASK_RST;
		end
		else
		begin
			if (wr_ctrl)
			begin
				fstop_cfg_r <= w_data_r[`DFR_CTRL_FSTOP_HI:`DFR_CTRL_FSTOP_LO];
				astop_cfg_r <= w_data_r[`DFR_CTRL_ASTOP_HI:`DFR_CTRL_ASTOP_LO];
			end
			if (wr_fs0)
				func_sel_r[0] <= w_data_r[7:0];
			if (wr_fs1)
				func_sel_r[1] <= w_data_r[7:0];
			if (wr_imask)
				irq_mask_r <= w_data_r[`DFR_EV_N-1:0];
		end
	end

	// Fault latch: a new fault in the reset cycle stays latched
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			fault_r      <= 1'b0;
			fault_code_r <= `DFR_CODE_NONE;
			fault_sel_r  <= 1'b0;
		end
		else if (fault_event & (~fault_r | fault_reset))
		begin
			fault_r      <= 1'b1;
			fault_code_r <= fault_code;
			fault_sel_r  <= fault_stop_selectable;
		end
		else if (fault_reset)
			fault_r <= 1'b0;
	end

	// Tuning error held until the next tuning run starts; copy error until a key press
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			tune_r      <= 1'b0;
			tune_code_r <= `DFR_CODE_NONE;
			copy_r      <= 1'b0;
			copy_code_r <= `DFR_CODE_NONE;
		end
		else
		begin
			if (tuning_error)
			begin
				tune_r      <= 1'b1;
				tune_code_r <= error_code;
			end
			else if (tuning_start)
				tune_r <= 1'b0;
			if (copy_error)
			begin
				copy_r      <= 1'b1;
				copy_code_r <= error_code;
			end
			else if (key_press)
				copy_r <= 1'b0;
		end
	end

	// Alarm and operation error follow their causes directly
	wire alarm_on  = alarm_present;
	wire oper_on   = setting_conflict;
	wire alarm_rise = alarm_on & ~alarm_prev_r;
	wire oper_rise  = oper_on & ~oper_prev_r;

	// Display priority; fault first so its lamp stays steady
	dfr_show_type show_nxt;
	logic [7:0]   code_nxt;
	always_comb
	begin
		show_nxt = DFR_SHOW_NONE;
		code_nxt = `DFR_CODE_NONE;
		if (fault_r)
		begin
			show_nxt = DFR_SHOW_FAULT;
			code_nxt = fault_code_r;
		end
		else if (tune_r)
		begin
			show_nxt = DFR_SHOW_TUNE;
			code_nxt = tune_code_r;
		end
		else if (oper_on)
		begin
			show_nxt = DFR_SHOW_OPER;
			code_nxt = conflict_code;
		end
		else if (copy_r)
		begin
			show_nxt = DFR_SHOW_COPY;
			code_nxt = copy_code_r;
		end
		else if (alarm_on)
		begin
			show_nxt = DFR_SHOW_ALARM;
			code_nxt = alarm_code;
		end
	end

	// Motor stop decision; coast means output is cut at once
	wire          alarm_stop = alarm_on & alarm_stop_request;
	dfr_stop_type stop_nxt;
	assign stop_nxt = fault_r ? (fault_sel_r ? dfr_stop_type'(fstop_cfg_r)
		: DFR_STOP_COAST)
		: tune_r ? DFR_STOP_COAST
		: alarm_stop ? dfr_stop_type'(astop_cfg_r)
		: DFR_STOP_COAST;
	wire stopping   = fault_r | tune_r | alarm_stop;
	wire permit_nxt = ~fault_r & ~oper_on & ~tune_r;
	wire motor_nxt  = ~(stopping & (stop_nxt == DFR_STOP_COAST)) &
		~(oper_on & ~stopping);

	// Programmable outputs see only the alarm state
	logic [`DFR_N_PROG_OUT-1:0] prog_nxt;
	always_comb
	begin
		for (int i = 0; i < `DFR_N_PROG_OUT; i++)
			prog_nxt[i] = alarm_on & (func_sel_r[i] == `DFR_FUNC_MINOR);
	end

	// Registered panel, contact and motor outputs
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			disp_code_r  <= `DFR_CODE_NONE;
			disp_class_r <= DFR_SHOW_NONE;
			make_r       <= 1'b0;
			permit_r     <= 1'b0;
			motor_en_r   <= 1'b0;
			stop_r       <= DFR_STOP_COAST;
			prog_r       <= '0;
			alarm_prev_r <= 1'b0;
			oper_prev_r  <= 1'b0;
		end
		else
		begin
			disp_code_r  <= code_nxt;
			disp_class_r <= show_nxt;
			make_r       <= fault_r;
			permit_r     <= permit_nxt;
			motor_en_r   <= motor_nxt;
			stop_r       <= stop_nxt;
			prog_r       <= prog_nxt;
			alarm_prev_r <= alarm_on;
			oper_prev_r  <= oper_on;
		end
	end

	// Flash only while an alarm is on top of the display
	wire flash_on = (disp_class_r == DFR_SHOW_ALARM);
	logic blink;
	dfr_blinker #(
		.HALF_CYCLES (BLINK_HALF_CYCLES)
	) u_blink (
		.clock (clock),
		.rstn  (rstn),
		.run   (flash_on),
		.blink (blink)
	);

	assign display_code           = disp_code_r;
	assign display_class          = disp_class_r;
	assign display_flash          = flash_on;
	assign trouble_lamp           = make_r | (flash_on & blink);
	assign fault_relay_make_path  = make_r;
	assign fault_relay_break_path = ~make_r;
	assign programmable_output    = prog_r;
	assign run_permit             = permit_r;
	assign motor_output_enable    = motor_en_r;
	assign stop_method            = stop_r;

	// Sticky events; a set in the clear cycle wins
	logic [`DFR_EV_N-1:0] ev;
	assign ev[`DFR_EV_FAULT] = fault_event;
	assign ev[`DFR_EV_ALARM] = alarm_rise;
	assign ev[`DFR_EV_OPER]  = oper_rise;
	assign ev[`DFR_EV_TUNE]  = tuning_error;
	assign ev[`DFR_EV_COPY]  = copy_error;
	wire [`DFR_EV_N-1:0] clr = wr_istat ? w_data_r[`DFR_EV_N-1:0] : '0;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			irq_stat_r <= '0;
		else
			irq_stat_r <= (irq_stat_r & ~clr) | ev;
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// Read decode
	wire [31:0] rd_status = {25'h000_0000, motor_en_r, permit_r,
		copy_r, tune_r, oper_on, alarm_on, fault_r};
	logic [31:0] rd_mux;
	logic        rd_hit;
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (araddr)
			`DFR_REG_CTRL:      rd_mux = {27'h000_0000, astop_cfg_r,
				fstop_cfg_r, 1'b0};
			`DFR_REG_FUNC_SEL0: rd_mux = {24'h00_0000, func_sel_r[0]};
			`DFR_REG_FUNC_SEL1: rd_mux = {24'h00_0000, func_sel_r[1]};
			`DFR_REG_STATUS:    rd_mux = rd_status;
			`DFR_REG_IRQ_STAT:  rd_mux = {27'h000_0000, irq_stat_r};
			`DFR_REG_IRQ_MASK:  rd_mux = {27'h000_0000, irq_mask_r};
			`DFR_REG_CODE:      rd_mux = {21'h00_0000, disp_class_r,
				disp_code_r};
			default:            rd_hit = 1'b0;
		endcase
	end

	assign arready = ~rvalid_r;

	// Read answer one cycle after the address is taken
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= `DFR_RESP_OKAY;
		end
		else if (arvalid & ~rvalid_r)
		begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_mux;
			rresp_r  <= rd_hit ? `DFR_RESP_OKAY : `DFR_RESP_SLVERR;
		end
		else if (rvalid_r & rready)
			rvalid_r <= 1'b0;
	end

	assign bvalid = bvalid_r;
	assign bresp  = bresp_r;
	assign rvalid = rvalid_r;
	assign rdata  = rdata_r;
	assign rresp  = rresp_r;

endmodule

// *** verification/dfr_fault_assertions.sv ***
/*
 Concurrent checks on the fault response controller ports.
 Assumes binding onto dfr_top; one clock, reset rstn active low.
*/
`include "dfr_defs.svh"
module dfr_fault_assertions
(
	// Clock and reset
	input wire logic                  clock,
	input wire logic                  rstn,
	// Causes
	input wire logic                  bvalid,
	input wire logic                  fault_event,
	input wire logic                  fault_stop_selectable,
	input wire logic                  alarm_present,
	input wire logic                  setting_conflict,
	input wire logic                  tuning_error,
	// Indications and contacts
	input wire dfr_pkg::dfr_show_type display_class,
	input wire logic                  display_flash,
	input wire logic                  trouble_lamp,
	input wire logic                  fault_relay_make_path,
	input wire logic                  fault_relay_break_path,
	input wire logic [`DFR_N_PROG_OUT-1:0] programmable_output,
	input wire logic                  run_permit,
	input wire logic                  motor_output_enable,
	input wire dfr_pkg::dfr_stop_type stop_method
);
	timeunit 1ns;
	timeprecision 1ps;
	import dfr_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	relay_inverse_a: assert property (fault_relay_break_path ==
		!fault_relay_make_path) else $error("relay paths not inverse");
	fault_trip_a: assert property (fault_event |-> ##2
		fault_relay_make_path && !run_permit) else $error("no trip");
	coast_stop_a: assert property (fault_event && !fault_stop_selectable
		&& !fault_relay_make_path |-> ##2 !motor_output_enable
		&& stop_method == DFR_STOP_COAST) else $error("no coast");
	fault_lamp_a: assert property (fault_relay_make_path |->
		trouble_lamp && display_class == DFR_SHOW_FAULT)
		else $error("fault not shown steady");
	fault_hold_a: assert property ($fell(fault_relay_make_path) |->
		$past(bvalid)) else $error("fault cleared without reset");
	alarm_out_a: assert property (!alarm_present |=>
		programmable_output == '0) else $error("output stays closed");
	minor_cause_a: assert property (programmable_output != '0 |->
		$past(alarm_present)) else $error("output without alarm");
	flash_rank_a: assert property (display_flash |->
		!fault_relay_make_path) else $error("flash during fault");
	conflict_stop_a: assert property (setting_conflict |=>
		!run_permit) else $error("run permitted in conflict");
	tune_coast_a: assert property (tuning_error |-> ##[1:2]
		!motor_output_enable) else $error("tuning error runs motor");
	make_cause_a: assert property ($rose(fault_relay_make_path) |->
		$past(fault_event, 2)) else $error("relay moved without fault");

	// Main scenarios reached
	cover property (fault_event ##2 fault_relay_make_path);
	cover property (display_flash && programmable_output != '0);
	cover property (setting_conflict ##1 !run_permit);
endmodule
bind dfr_top dfr_fault_assertions chk_u (.*);

// *** verification/dfr_panel_model.sv ***
/*
 Operator panel: presses keys and watches the trouble lamp.
 Assumes the bench calls press and reads lamp_edges.
*/
module dfr_panel_model
(
	// Clock
	input wire logic clock,
	// Indication watched
	input wire logic trouble_lamp,
	// Key line, high while any key is held
	output logic     panel_key_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	int   lamp_edges = 0;
	logic lamp_q = 1'h0;

	initial panel_key_pin = 1'h0;

	// Lamp transitions, so steady and flashing can be told apart
	always @(posedge clock)
	begin
		lamp_q <= trouble_lamp;
		if (lamp_q !== trouble_lamp)
			lamp_edges++;
	end

	// Key held long enough to pass the pin synchroniser
	task press;
		@(posedge clock);
		panel_key_pin <= 1'h1;
		repeat (4) @(posedge clock);
		panel_key_pin <= 1'h0;
	endtask
endmodule

// *** verification/testbench.sv ***
/*
 Self-checking bench: AXI4-Lite register calls and detection stimulus.
 Assumes dfr_pkg and dfr_defs.svh are compiled first.
*/
`include "dfr_defs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import dfr_pkg::*;
	logic        clock, rstn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr, fault_code, alarm_code;
	logic [7:0]  conflict_code, error_code;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, programmable_output;
	logic        fault_event, fault_stop_selectable, alarm_present;
	logic        alarm_stop_request, setting_conflict, tuning_start;
	logic        tuning_error, copy_error, panel_key_pin, awready;
	logic        wready, bvalid, arready, rvalid, display_flash, irq;
	logic        trouble_lamp, fault_relay_make_path, run_permit;
	logic        fault_relay_break_path, motor_output_enable;
	logic [7:0]  display_code;
	dfr_show_type display_class;
	dfr_stop_type stop_method;
	int          num_errors = 0, tests_run = 0, cycles = 0, e0;
	localparam logic [1:0] OK = `DFR_RESP_OKAY, ERR = `DFR_RESP_SLVERR;

	dfr_top #(.BLINK_HALF_CYCLES(4)) dut_u (.*);
	dfr_panel_model panel_u (.clock, .trouble_lamp, .panel_key_pin);

	// Clock and hang guard
	initial
	begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			tally_and_finish;
		end
	end

	task tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Outputs settle well before the falling edge
	task wt(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask

	// Write: address and data offered together, held until taken
	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		do
		begin
			@(posedge clock);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end
		while (!bvalid);
		chk(bresp, r);
		bready <= 1'h0;
	endtask

	task axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge clock);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do
		begin
			@(posedge clock);
			if (arready) arvalid <= 1'h0;
		end
		while (!rvalid);
		chk(rdata, e);
		chk(rresp, r);
		rready <= 1'h0;
	endtask

	task pf(input logic [7:0] c, input logic s);
		@(posedge clock);
		{fault_event, fault_stop_selectable, fault_code} <= {1'h1, s, c};
		@(posedge clock);
		fault_event <= 1'h0;
		wt(3);
	endtask

	// Display word, then make, break, permit, motor enable
	task see(input logic [10:0] dc, input logic [3:0] cr);
		chk({display_class, display_code}, dc);
		chk({fault_relay_make_path, fault_relay_break_path, run_permit,
			motor_output_enable}, cr);
	endtask

	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, fault_event} = '0;
		{fault_stop_selectable, alarm_present, alarm_stop_request} = '0;
		{setting_conflict, tuning_start, tuning_error, copy_error} = '0;
		{awaddr, araddr, fault_code, alarm_code} = '0;
		{conflict_code, error_code, wdata} = '0;
		wstrb = 4'hF;
		rstn = 1'h0;
		repeat (3) @(posedge clock);
		rstn <= 1'h1;
		wt(3);
		axr(`DFR_REG_STATUS, 32'h0000_0060, OK);
		axr(`DFR_REG_FUNC_SEL0, 32'h0000_0000, OK);
		axr(`DFR_REG_CODE, 32'h0000_0000, OK);
		axr(8'h1C, 32'h0000_0000, ERR);
		axw(8'h1C, 32'h0000_0000, ERR);
		$display("reset and map test done");
		pf(8'h21, 1'h0);
		see({DFR_SHOW_FAULT, 8'h21}, 4'h8);
		chk(stop_method, DFR_STOP_COAST);
		pf(8'h22, 1'h0);
		see({DFR_SHOW_FAULT, 8'h21}, 4'h8);
		axw(`DFR_REG_CTRL, 32'h0000_0001, OK);
		wt(2);
		see({DFR_SHOW_NONE, 8'h00}, 4'h7);
		axw(`DFR_REG_CTRL, 32'h0000_0004, OK);
		pf(8'h23, 1'h1);
		chk(stop_method, DFR_STOP_FAST);
		see({DFR_SHOW_FAULT, 8'h23}, 4'h9);
		axw(`DFR_REG_CTRL, 32'h0000_0001, OK);
		$display("fault test done");
		axw(`DFR_REG_FUNC_SEL0, 32'h0000_000A, OK);
		axw(`DFR_REG_FUNC_SEL1, 32'h0000_0009, OK);
		{alarm_present, alarm_code} <= {1'h1, 8'h33};
		wt(3);
		see({DFR_SHOW_ALARM, 8'h33}, 4'h7);
		chk({display_flash, programmable_output}, 3'h5);
		e0 = panel_u.lamp_edges;
		wt(20);
		chk(panel_u.lamp_edges - e0 > 2, 1'h1);
		pf(8'h24, 1'h0);
		see({DFR_SHOW_FAULT, 8'h24}, 4'h8);
		e0 = panel_u.lamp_edges;
		wt(20);
		chk({panel_u.lamp_edges == e0, trouble_lamp}, 2'h3);
		axw(`DFR_REG_CTRL, 32'h0000_0009, OK);
		alarm_stop_request <= 1'h1;
		wt(3);
		chk(stop_method, DFR_STOP_RAMP);
		see({DFR_SHOW_ALARM, 8'h33}, 4'h7);
		@(posedge clock);
		{alarm_present, alarm_stop_request} <= 2'h0;
		wt(3);
		see({DFR_SHOW_NONE, 8'h00}, 4'h7);
		chk({programmable_output, trouble_lamp}, 3'h0);
		$display("alarm test done");
		@(posedge clock);
		{setting_conflict, conflict_code} <= {1'h1, 8'h44};
		wt(3);
		see({DFR_SHOW_OPER, 8'h44}, 4'h4);
		chk(programmable_output, 2'h0);
		@(posedge clock);
		setting_conflict <= 1'h0;
		wt(3);
		see({DFR_SHOW_NONE, 8'h00}, 4'h7);
		@(posedge clock);
		{tuning_error, error_code} <= {1'h1, 8'h55};
		@(posedge clock);
		tuning_error <= 1'h0;
		wt(3);
		see({DFR_SHOW_TUNE, 8'h55}, 4'h4);
		chk(stop_method, DFR_STOP_COAST);
		@(posedge clock);
		tuning_start <= 1'h1;
		@(posedge clock);
		tuning_start <= 1'h0;
		{copy_error, error_code} <= {1'h1, 8'h66};
		@(posedge clock);
		copy_error <= 1'h0;
		wt(3);
		see({DFR_SHOW_COPY, 8'h66}, 4'h7);
		panel_u.press();
		wt(3);
		see({DFR_SHOW_NONE, 8'h00}, 4'h7);
		$display("error test done");
		axr(`DFR_REG_IRQ_STAT, 32'h0000_001F, OK);
		chk(irq, 1'h0);
		axw(`DFR_REG_IRQ_MASK, 32'h0000_0001, OK);
		wt(1);
		chk(irq, 1'h1);
		axw(`DFR_REG_IRQ_STAT, 32'h0000_001F, OK);
		wt(1);
		axr(`DFR_REG_IRQ_STAT, 32'h0000_0000, OK);
		chk(irq, 1'h0);
		$display("interrupt test done");
		tally_and_finish;
	end
endmodule
